// >>> src/hams_pkg.sv
// Shared constants and types of the angle measurement sequencer.
// Assumes a 20 MHz mclk and an APB master with 32-bit data.
package hams_pkg;

  // ==========================================================
  // Time base
  localparam int CLK_NS           = 50;
  localparam int US_NS            = 1000;
  localparam int US_CYC           = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACTIVE_US        = 220;
  localparam int HOLD_US          = 108;
  localparam int CONV_BASE_US     = 69;
  localparam int CONV_STEP_LOG2   = 5;
  localparam int MEAS_CONV        = 2;
  localparam int INTERVAL_UNIT_US = 100;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD  = 8'h00;
  localparam logic [7:0] OFS_CFG  = 8'h04;
  localparam logic [7:0] OFS_THR  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RES  = 8'h10;

  // ==========================================================
  // Field positions and reset values
  localparam int CFG_OSR_LSB  = 0;
  localparam int CFG_FLT_LSB  = 2;
  localparam int CFG_IVL_LSB  = 8;
  localparam int ST_CONT      = 0;
  localparam int ST_WAKE      = 1;
  localparam int ST_SINGLE    = 2;
  localparam int ST_FAIL      = 3;
  localparam int ST_RESULT_READY_FLAG      = 4;
  localparam int ST_ALERT     = 5;
  localparam int ST_STATE_LSB = 8;
  localparam int RES_MAG_LSB  = 16;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] THR_RST = 16'h0000;

  // ==========================================================
  // Commands (also the running mode) and sequencer states
  typedef enum logic [1:0] {
    CMD_IDLE   = 2'b00,
    CMD_CONT   = 2'b01,
    CMD_WAKE   = 2'b10,
    CMD_SINGLE = 2'b11
  } hams_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ACTIVE = 3'b001,
    S_CONV   = 3'b010,
    S_HOLD   = 3'b011,
    S_STBY   = 3'b100
  } hams_state_t;

endpackage

// >>> src/hams_cordic.sv
// Iterative vectoring rotator: angle and magnitude of an X/Y pair.
// Assumes start is a one-cycle pulse with x_in and y_in stable at it.
module hams_cordic #(
  parameter int W    = 16,
  parameter int ITER = 16
) (
  // System
  input  wire logic                clk,
  input  wire logic                rst,
  // Request
  input  wire logic                start,
  input  wire logic signed [W-1:0] x_in,
  input  wire logic signed [W-1:0] y_in,
  // Answer
  output logic         [W-1:0]     angle,
  output logic         [W-1:0]     magnitude,
  output logic                     done
);

  localparam int IW = W + 3;
  localparam int CW = $clog2(ITER);

  // ==========================================================
  // Arctangent of 2^-i, full turn = 2^16
  function automatic logic [15:0] atan_lut(input logic [CW-1:0] i);
    unique case (i)
      4'h0:    atan_lut = 16'h2000;
      4'h1:    atan_lut = 16'h12E4;
      4'h2:    atan_lut = 16'h09FB;
      4'h3:    atan_lut = 16'h0511;
      4'h4:    atan_lut = 16'h028B;
      4'h5:    atan_lut = 16'h0146;
      4'h6:    atan_lut = 16'h00A3;
      4'h7:    atan_lut = 16'h0051;
      4'h8:    atan_lut = 16'h0029;
      4'h9:    atan_lut = 16'h0014;
      4'hA:    atan_lut = 16'h000A;
      4'hB:    atan_lut = 16'h0005;
      4'hC:    atan_lut = 16'h0003;
      4'hD:    atan_lut = 16'h0001;
      4'hE:    atan_lut = 16'h0001;
      default: atan_lut = 16'h0000;
    endcase
  endfunction

  logic signed [IW-1:0] x_reg, y_reg, x_sh, y_sh;
  logic        [15:0]   z_reg;
  logic        [CW-1:0] idx_reg;
  logic                 busy_reg;
  logic                 last;

  assign x_sh = x_reg >>> idx_reg;
  assign y_sh = y_reg >>> idx_reg;
  assign last = (idx_reg == CW'(ITER - 1));

  // ==========================================================
  // Left half-plane is folded by 180 degrees so the loop converges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      x_reg    <= '0;
      y_reg    <= '0;
      z_reg    <= 16'h0000;
      idx_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (start) begin
      x_reg    <= x_in[W-1] ? -IW'(x_in) : IW'(x_in);
      y_reg    <= x_in[W-1] ? -IW'(y_in) : IW'(y_in);
      z_reg    <= x_in[W-1] ? 16'h8000 : 16'h0000;
      idx_reg  <= '0;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      x_reg    <= y_reg[IW-1] ? x_reg - y_sh : x_reg + y_sh;
      y_reg    <= y_reg[IW-1] ? y_reg + x_sh : y_reg - x_sh;
      z_reg    <= y_reg[IW-1] ? z_reg - atan_lut(idx_reg) : z_reg + atan_lut(idx_reg);
      idx_reg  <= idx_reg + CW'(1);
      busy_reg <= !last;
    end
  end

  // Results registered; magnitude keeps the rotator gain and saturates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      angle     <= '0;
      magnitude <= '0;
      done      <= 1'b0;
    end else begin
      done <= busy_reg && last;
      if (busy_reg && last) begin
        angle     <= z_reg[15 -: W];
        magnitude <= (x_reg[IW-1:W] != '0) ? {W{1'b1}} : x_reg[W-1:0];
      end
    end
  end

endmodule

// >>> src/hams_sequencer.sv
// Measurement-mode sequencer of a two-axis angle sensor, APB slave.
// Assumes adc_data is valid at the end of each conversion, same clock.
module hams_sequencer
  import hams_pkg::*;
#(
  parameter int US_CYCLES = US_CYC,
  parameter int ACT_US    = ACTIVE_US,
  parameter int END_US    = HOLD_US
) (
  // System
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and analog front end
  input  wire logic        trig_pin,
  input  wire logic [15:0] adc_data,
  output logic             afe_en,
  output logic             conv_axis,
  output logic             alert
);

  hams_state_t st_reg, st_next;
  hams_cmd_t   mode_reg, cmd_code, req_code;
  logic [15:0] div_reg, us_cnt, load_val, cfg_reg, thr_reg, conv_us, ivl_us;
  logic [15:0] x_reg, y_reg, ang_reg, mag_reg, cor_ang, cor_mag;
  logic [31:0] rd_val, stat_word;
  logic [7:0]  conv_span;
  logic [2:0]  trig_sync_reg;
  logic        trig_lvl_reg, trig_rise, tick, load, us_done, conv_idx, last_conv;
  logic        busy, idle_pend, err_reg, result_ready_flag_reg, cor_go, cor_done, meas_done;
  logic        setup, acc, hit_cmd, hit_cfg, hit_thr, hit_stat, hit_res, mapped;
  logic        refused, bad_dir, wr_ok, cmd_wr, cfg_wr, thr_wr, res_rd, cmd_ev;
  logic        meas_req, start_meas, meas_err, idle_req, over_thr, result_ready_flag_set, alert_set;

  // ==========================================================
  // APB decode; zero wait states, error on refusal, bad address or a write to status or result
  assign setup    = psel && !penable;
  assign acc      = psel && penable;
  assign hit_cmd  = (paddr == OFS_CMD);
  assign hit_cfg  = (paddr == OFS_CFG);
  assign hit_thr  = (paddr == OFS_THR);
  assign hit_stat = (paddr == OFS_STAT);
  assign hit_res  = (paddr == OFS_RES);
  assign mapped   = hit_cmd || hit_cfg || hit_thr || hit_stat || hit_res;
  assign busy     = (mode_reg != CMD_IDLE);
  assign refused  = (hit_cfg || hit_thr) && busy;
  assign bad_dir  = pwrite && (hit_stat || hit_res);
  assign pready   = 1'b1;
  assign pslverr  = acc && (!mapped || refused || bad_dir);
  assign wr_ok    = acc && pwrite && !pslverr;
  assign cmd_wr   = wr_ok && hit_cmd;
  assign cfg_wr   = wr_ok && hit_cfg;
  assign thr_wr   = wr_ok && hit_thr;
  assign res_rd   = acc && !pwrite && hit_res;

  // ==========================================================
  // Trigger pin: three flops, level accepted when stages two and three agree
  assign trig_rise = trig_sync_reg[1] && trig_sync_reg[2] && !trig_lvl_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_sync_reg <= 3'h0;
      trig_lvl_reg  <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], trig_pin};
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_lvl_reg <= trig_sync_reg[1];
      end
    end
  end

  // ==========================================================
  // Command decode; the pin pulse acts exactly like a single-shot write
  assign cmd_code   = hams_cmd_t'(pwdata[1:0]);
  assign meas_req   = (cmd_wr && cmd_code != CMD_IDLE) || trig_rise;
  assign req_code   = (cmd_wr && cmd_code != CMD_IDLE) ? cmd_code : CMD_SINGLE;
  assign start_meas = meas_req && !busy;
  assign meas_err   = meas_req && busy;
  assign idle_req   = cmd_wr && (cmd_code == CMD_IDLE) && busy;
  assign cmd_ev     = cmd_wr || trig_rise || (acc && (hit_cfg || hit_thr)) || res_rd;

  // ==========================================================
  // Timing: conversion length from oversampling and filter settings
  assign conv_span = 8'(8'd2 + (8'd1 << cfg_reg[CFG_FLT_LSB +: 3]));
  assign conv_us   = 16'(CONV_BASE_US)
                   + ((16'(conv_span) << cfg_reg[CFG_OSR_LSB +: 2]) << CONV_STEP_LOG2);
  assign ivl_us    = 16'(16'(cfg_reg[CFG_IVL_LSB +: 8]) * 16'(INTERVAL_UNIT_US));
  assign tick      = (div_reg == 16'(US_CYCLES - 1));
  assign us_done   = tick && (us_cnt == 16'h0000);
  assign last_conv = (conv_idx == 1'(MEAS_CONV - 1));
  assign meas_done = (st_reg == S_HOLD) && us_done;

  // Microsecond divider restarts on each load so every span is exact
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= 16'h0000;
      us_cnt  <= 16'h0000;
    end else begin
      div_reg <= (load || tick) ? 16'h0000 : div_reg + 16'h0001;
      if (load) begin
        us_cnt <= load_val;
      end else if (tick && us_cnt != 16'h0000) begin
        us_cnt <= us_cnt - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    st_next  = st_reg;
    load     = 1'b0;
    load_val = 16'h0000;
    unique case (st_reg)
      S_IDLE: if (start_meas) begin
        st_next  = S_ACTIVE;
        load     = 1'b1;
        load_val = 16'(ACT_US - 1);
      end
      S_ACTIVE: if (us_done) begin
        st_next  = S_CONV;
        load     = 1'b1;
        load_val = conv_us - 16'h0001;
      end
      S_CONV: if (us_done) begin
        load = 1'b1;
        if (last_conv) begin
          st_next  = S_HOLD;
          load_val = 16'(END_US - 1);
        end else begin
          load_val = conv_us - 16'h0001;
        end
      end
      S_HOLD: if (us_done) begin
        if (mode_reg == CMD_SINGLE || idle_pend) begin
          st_next = S_IDLE;
        end else if (ivl_us == 16'h0000) begin
          st_next  = S_CONV;
          load     = 1'b1;
          load_val = conv_us - 16'h0001;
        end else begin
          st_next  = S_STBY;
          load     = 1'b1;
          load_val = ivl_us - 16'h0001;
        end
      end
      S_STBY: if (idle_pend) begin
        st_next = S_IDLE;
      end else if (us_done) begin
        st_next  = S_CONV;
        load     = 1'b1;
        load_val = conv_us - 16'h0001;
      end
      default: st_next = S_IDLE;
    endcase
  end

  // ==========================================================
  // State, mode and pending idle; analog enabled while measuring
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg    <= S_IDLE;
      mode_reg  <= CMD_IDLE;
      idle_pend <= 1'b0;
      afe_en    <= 1'b0;
      conv_idx  <= 1'b0;
      conv_axis <= 1'b0;
      cor_go    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      idle_pend <= (idle_pend || idle_req) && (st_next != S_IDLE);
      afe_en    <= (st_next == S_ACTIVE) || (st_next == S_CONV) || (st_next == S_HOLD);
      conv_idx  <= (st_reg == S_CONV) ? conv_idx ^ us_done : 1'b0;
      conv_axis <= (st_next == S_CONV) && (st_reg == S_CONV) ? conv_idx ^ us_done : 1'b0;
      cor_go    <= (st_reg == S_CONV) && us_done && last_conv;
      if (start_meas) begin
        mode_reg <= req_code;
      end else if (st_next == S_IDLE) begin
        mode_reg <= CMD_IDLE;
      end
    end
  end

  // ==========================================================
  // Field samples: first conversion is X, second is Y
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
    end else if (st_reg == S_CONV && us_done) begin
      if (conv_idx) y_reg <= adc_data;
      else          x_reg <= adc_data;
    end
  end

  // Rotator runs inside the hold window, long before it closes
  hams_cordic #(.W(16), .ITER(16)) u_cordic (
    .clk       (mclk),
    .rst       (rst),
    .start     (cor_go),
    .x_in      (x_reg),
    .y_in      (y_reg),
    .angle     (cor_ang),
    .magnitude (cor_mag),
    .done      (cor_done)
  );

  // ==========================================================
  // Results and flags; a set in the same cycle as a readback wins
  assign over_thr  = (cor_ang > thr_reg);
  assign result_ready_flag_set  = meas_done && (mode_reg != CMD_WAKE || over_thr);
  assign alert_set = meas_done && (mode_reg == CMD_WAKE) && over_thr;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ang_reg  <= 16'h0000;
      mag_reg  <= 16'h0000;
      result_ready_flag_reg <= 1'b0;
      alert    <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      if (meas_done) begin
        ang_reg <= cor_ang;
        mag_reg <= cor_mag;
      end
      result_ready_flag_reg <= result_ready_flag_set || (result_ready_flag_reg && !res_rd);
      alert    <= alert_set || (alert && !res_rd);
      if (cmd_ev) begin
        err_reg <= meas_err || (acc && refused);
      end
    end
  end

  // ==========================================================
  // Software-written settings, ignored while a mode runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RST;
      thr_reg <= THR_RST;
    end else begin
      if (cfg_wr) cfg_reg <= pwdata[15:0];
      if (thr_wr) thr_reg <= pwdata[15:0];
    end
  end

  // ==========================================================
  // Read path: data captured in setup, presented in the access phase
  always_comb begin
    stat_word                         = 32'h0000_0000;
    stat_word[ST_CONT]                = (mode_reg == CMD_CONT);
    stat_word[ST_WAKE]                = (mode_reg == CMD_WAKE);
    stat_word[ST_SINGLE]              = (mode_reg == CMD_SINGLE);
    stat_word[ST_FAIL]                = err_reg;
    stat_word[ST_RESULT_READY_FLAG]                = result_ready_flag_reg;
    stat_word[ST_ALERT]               = alert;
    stat_word[ST_STATE_LSB +: 3]      = st_reg;
  end

  assign rd_val = hit_cfg  ? {16'h0000, cfg_reg} :
                  hit_thr  ? {16'h0000, thr_reg} :
                  hit_stat ? stat_word :
                  hit_res  ? {mag_reg, ang_reg} : 32'h0000_0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= (!pwrite && !refused) ? rd_val : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_last_conv;
    (st_reg == S_CONV) && us_done && conv_idx;
  endsequence

  property p_conv_pair;
    ((st_reg == S_CONV) && us_done && !conv_idx) |=>
      (st_reg == S_CONV) && conv_idx && (us_cnt == conv_us - 16'h0001);
  endproperty
  a_conv_pair: assert property (p_conv_pair) else $error("second conversion wrong");

  property p_hold;
    s_last_conv |=> (st_reg == S_HOLD) && afe_en && (us_cnt == 16'(END_US - 1));
  endproperty
  a_hold: assert property (p_hold) else $error("hold window wrong");

  property p_active;
    ((st_reg == S_IDLE) && start_meas) |=>
      (st_reg == S_ACTIVE) && (us_cnt == 16'(ACT_US - 1)) && afe_en;
  endproperty
  a_active: assert property (p_active) else $error("wake latency wrong");

  property p_single;
    (meas_done && mode_reg == CMD_SINGLE) |=>
      (st_reg == S_IDLE) && (mode_reg == CMD_IDLE) && result_ready_flag_reg && !afe_en;
  endproperty
  a_single: assert property (p_single) else $error("single shot did not idle");

  property p_refuse;
    (acc && pwrite && hit_cfg && busy) |-> pslverr ##1
      (cfg_reg == $past(cfg_reg)) && err_reg;
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy access not refused");

  property p_alert_hold;
    (alert && !res_rd) |=> alert;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped");

  property p_alert_clr;
    (res_rd && !meas_done) |=> !alert && !result_ready_flag_reg;
  endproperty
  a_alert_clr: assert property (p_alert_clr) else $error("readback kept flags");

  property p_trig;
    (trig_rise && !busy) |=> (st_reg == S_ACTIVE) && (mode_reg == CMD_SINGLE);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start");

  property p_idle_finish;
    (idle_pend && st_reg == S_CONV) |=> (st_reg != S_IDLE);
  endproperty
  a_idle_finish: assert property (p_idle_finish) else $error("idle cut measurement");

  property p_wake_alert;
    (meas_done && mode_reg == CMD_WAKE && over_thr) |=> alert && result_ready_flag_reg;
  endproperty
  a_wake_alert: assert property (p_wake_alert) else $error("alert not raised");

  // Rotator must finish well inside the hold window
  property p_rot_time;
    cor_go |-> ##17 cor_done;
  endproperty
  a_rot_time: assert property (p_rot_time) else $error("rotator late");

endmodule

// >>> sim/hams_afe_model.sv
// Analog front end stand-in: hands the sequencer the X or Y field sample.
// Assumes conv_axis picks the axis and afe_en powers the channel.
module hams_afe_model (
  // System
  input  wire logic        mclk,
  // Sequencer side
  input  wire logic        afe_en,
  input  wire logic        conv_axis,
  output logic      [15:0] adc_data = 16'h5A5A,
  // Field seen by the probe
  input  wire logic [15:0] x_val,
  input  wire logic [15:0] y_val
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Sample path
  // Powered down the output toggles, so a stale sample never looks valid
  always @(posedge mclk) begin
    if (afe_en) begin
      adc_data <= conv_axis ? y_val : x_val;
    end else begin
      adc_data <= ~adc_data;
    end
  end
endmodule

// >>> sim/hall_angle_measurement_sequencer_bench.sv
// Testbench of the angle sequencer: APB host plus front end model.
// Assumes US_CYCLES=1, so one microsecond is one mclk cycle.
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module hall_angle_measurement_sequencer_bench
  import hams_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic        trig_pin = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [15:0] x_val    = 16'h1000;
  logic [15:0] y_val    = 16'h1000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] adc_data;
  logic        pready;
  logic        pslverr;
  logic        afe_en;
  logic        conv_axis;
  logic        alert;
  logic        err;
  int          n_mismatch = 0;
  int          checks     = 0;

  // ==========================================================
  // Clock, design and front end
  always #25 mclk = ~mclk;
  hams_sequencer #(.US_CYCLES(1)) dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin(trig_pin), .adc_data(adc_data),
    .afe_en(afe_en), .conv_axis(conv_axis), .alert(alert));
  hams_afe_model afe (.mclk(mclk), .afe_en(afe_en), .conv_axis(conv_axis),
    .adc_data(adc_data), .x_val(x_val), .y_val(y_val));

  // ==========================================================
  // Closing report, reached from the main sequence and from timeouts
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("unexpected pready exp 1 got %0b", pready);
      end_sim();
    end
  endtask

  // Cycles afe_en stays high in one burst
  task automatic afe_burst(output int len);
    int n;
    len = 0;
    for (n = 0; n < 9000 && !(len > 0 && afe_en === 1'b0); n++) begin
      @(posedge mclk);
      if (afe_en === 1'b1) len++;
    end
    if (n >= 9000) begin
      n_mismatch++;
      $display("unexpected afe_en burst end exp 0 got %0b", afe_en);
      end_sim();
    end
  endtask

  // Cycles between two Y conversion starts, i.e. one measurement period
  task automatic y_period(output int p);
    int n;
    logic prev;
    p = -1;
    prev = 1'b1;
    for (n = 0; n < 9000; n++) begin
      @(posedge mclk);
      if (conv_axis === 1'b1 && prev === 1'b0) begin
        if (p >= 0) break;
        p = 0;
      end
      if (p >= 0) p++;
      prev = conv_axis;
    end
    if (n >= 9000) begin
      n_mismatch++;
      $display("unexpected conv_axis period exp 1 got 0");
      end_sim();
    end
  endtask

  // Readback frame against the ideal angle and scaled magnitude
  task automatic chk_result();
    int ea;
    int em;
    ea = int'($atan2(real'(y_val), real'(x_val)) * 65536.0 / 6.2831853);
    em = int'(1.647 * $sqrt(real'(x_val) ** 2 + real'(y_val) ** 2));
    apb(1'b0, OFS_RES, 32'h0);
    `CHK("angle", 1'b1, (int'(rd[15:0]) - ea) inside {[-48:48]})
    `CHK("magnitude", 1'b1, (int'(rd[31:16]) - em) inside {[-em/64:em/64]})
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int c, p, o, f, len;
    void'($urandom(21344));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, an unmapped place and a read-only place
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg reset", 32'h0, rd)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("state reset", 3'h0, rd[10:8])
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, OFS_STAT, 32'hFF);
    `CHK("status write err", 1'b1, err)
    // Single shots over the oversample settings; the last by the pin
    for (o = 0; o < 4; o++) begin
      f = $urandom_range(2);
      c = 69 + 32 * (1 << o) * (2 + (1 << f));
      x_val <= 16'(1000 + $urandom_range(15000));
      y_val <= 16'(1000 + $urandom_range(15000));
      apb(1'b1, OFS_CFG, 32'(o) | (32'(f) << 2));
      if (o == 3) begin
        trig_pin <= 1'b1;
        fork
          begin repeat (8) @(posedge mclk); trig_pin <= 1'b0; end
        join_none
      end else begin
        apb(1'b1, OFS_CMD, 32'(CMD_SINGLE));
      end
      afe_burst(len);
      `CHK("single time", 220 + 2 * c + 108, len)
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK("ready set", 1'b1, rd[ST_RESULT_READY_FLAG])
      `CHK("self idle", 6'h0, {rd[10:8], rd[2:0]})
      chk_result();
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK("ready cleared", 1'b0, rd[ST_RESULT_READY_FLAG])
    end
    // Continuous: period, refused access, busy command, finishing idle
    apb(1'b1, OFS_CFG, 32'h0);
    apb(1'b1, OFS_CMD, 32'(CMD_CONT));
    y_period(p);
    `CHK("cont period", 2 * 165 + 108, p)
    apb(1'b1, OFS_CFG, 32'h0);
    `CHK("cfg refused", 1'b1, err)
    apb(1'b1, OFS_CMD, 32'(CMD_SINGLE));
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("busy fail", 2'b11, {rd[ST_FAIL], rd[ST_CONT]})
    apb(1'b1, OFS_CMD, 32'(CMD_IDLE));
    `CHK("still measuring", 1'b1, afe_en)
    afe_burst(len);
    `CHK("finish bound", 1'b1, len inside {[1:438]})
    // Continuous with an interval of two units in standby
    apb(1'b1, OFS_CFG, 32'h200);
    apb(1'b1, OFS_CMD, 32'(CMD_CONT));
    y_period(p);
    `CHK("interval period", 2 * 165 + 108 + 200, p)
    apb(1'b1, OFS_CMD, 32'(CMD_IDLE));
    afe_burst(len);
    // Wake-up: alert on crossing, kept when angle falls, cleared by readback
    apb(1'b1, OFS_THR, 32'h2000);
    apb(1'b1, OFS_CFG, 32'h0);
    x_val <= 16'h1000;
    y_val <= 16'h3000;
    apb(1'b1, OFS_CMD, 32'(CMD_WAKE));
    y_period(p);
    `CHK("wake period", 2 * 165 + 108, p)
    `CHK("alert raised", 1'b1, alert)
    x_val <= 16'h3000;
    y_val <= 16'h1000;
    y_period(p);
    `CHK("alert kept", 1'b1, alert)
    chk_result();
    @(posedge mclk);
    `CHK("alert released", 1'b0, alert)
    y_period(p);
    `CHK("alert below", 1'b0, alert)
    apb(1'b1, OFS_CMD, 32'(CMD_IDLE));
    afe_burst(len);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("idle again", 3'h0, rd[10:8])
    // Settings written in idle read back; the host idled first, so a reset is legal
    apb(1'b1, OFS_CFG, 32'h0000_0305);
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg write", 32'h305, rd)
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("afe at reset", 1'b0, afe_en)
    rst <= 1'b0;
    apb(1'b0, OFS_THR, 32'h0);
    `CHK("thr after reset", 32'h0, rd)
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg after reset", 32'h0, rd)
    end_sim();
  end
endmodule
